// ### inc/dsq_pkg.sv
// constants, types and state layout of the descriptor dma sequencer
package dsq_pkg;
    localparam int NCH = 4;
    // register map, byte addresses
    localparam logic [7:0] R_GCFG     = 8'h00;
    localparam logic [7:0] R_INTEN    = 8'h04;
    localparam logic [7:0] R_THROTTLE = 8'h08;
    localparam logic [7:0] R_STATUS   = 8'h0c;
    localparam logic [1:0] R_CH_SPACE = 2'h1;   // regAddr[7:6] for 0x40..0x7f
    localparam logic [3:0] R_CH_CFG   = 4'h0;
    localparam logic [3:0] R_CH_DBELL = 4'h4;
    localparam logic [3:0] R_CH_PTR   = 4'h8;
    // command word 0 fields
    localparam int C0_VALID = 31;
    localparam int C0_MEM   = 30;
    localparam int C0_DT    = 17;   // msb of 2-bit type code
    localparam int C0_SM    = 14;
    localparam int C0_IE    = 8;
    localparam int C0_CV    = 2;
    localparam logic [1:0] DT_NORMAL = 2'h0;
    localparam logic [1:0] DT_BRANCH = 2'h2;
    // command word 1 fields
    localparam int C1_SUP = 31;     // msb of 4-bit source upper address
    localparam int C1_DUP = 27;     // msb of 4-bit dest upper address
    localparam int C1_BC  = 21;     // msb of 22-bit byte count
    // source / dest parameter word fields
    localparam int P_AM  = 31;      // msb of 2-bit address mode
    localparam int P_SC  = 29;      // msb of 6-bit stride iterations
    localparam int P_STR = 23;      // msb of 12-bit stride length
    localparam int P_BLK = 11;      // msb of 12-bit block length
    localparam logic [1:0] AM_INCR = 2'h0;
    // descriptor word indexes
    localparam logic [2:0] W_CMD1 = 3'h1, W_SRC0 = 3'h2, W_SRC1 = 3'h3;
    localparam logic [2:0] W_DST0 = 3'h4, W_DST1 = 3'h5, W_NEXT = 3'h7;
    localparam logic [2:0] W_LAST = 3'h7;
    localparam logic [31:0] WORD_BYTES = 32'h4;
    localparam logic [21:0] WORD_BC    = 22'h4;

    typedef enum logic [2:0] {
        ST_IDLE, ST_FETCH, ST_SRC, ST_DST, ST_CMP, ST_WB, ST_DONE
    } dsq_state_t;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] base;
        logic [31:0] grp;
        logic [11:0] bcnt;
        logic [5:0]  iter;
    } dsq_side_t;

    typedef struct packed {
        dsq_state_t         state;
        logic [1:0]         ch;
        logic [1:0]         rr;
        logic [2:0]         w;
        logic [7:0][31:0]   desc;
        dsq_side_t          src;
        dsq_side_t          dst;
        logic [21:0]        remain;
        logic               take;
        logic               memReq;
        logic               memWe;
        logic [35:0]        memAddr;
        logic [31:0]        memWdata;
        logic [31:0]        rdata;
        logic               highPoolArbPolicy;
        logic               lowPoolArbPolicy;
        logic [3:0]         en;
        logic [3:0]         pend;
        logic [3:0]         irq;
        logic [3:0]         inten;
        logic [15:0]        throttle;
        logic [3:0][31:0]   desptr;
    } dsq_regs_t;

    localparam dsq_regs_t REGS_RST = '0;
endpackage

// ### hw/dsq_sequencer.sv
// descriptor dma channel sequencer with register port and memory master
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - valid descriptor untouched until engine clears it
// - doorbell write starts descriptor fetching
// - idle channel waits for its doorbell
// - valid descriptor runs whole transfer, updates status
// - pointer follows next or branch target
// - invalid descriptor stalls, refetched after doorbell
// - all channel enables clear means shutdown
// - memory flag and normal type code
// - stride select: one or two dimensions
// - address mode zero increments address
// - byte count gives total bytes moved
// - upper fields give address bits 35:32
// - block length and stride distance scatter blocks
// - two-dimensional stride iteration count
// - interrupt enable raises channel flag
module dsq_sequencer (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic      [31:0] regRdata,
    output logic             memReq,
    output logic             memWe,
    output logic      [35:0] memAddr,
    output logic      [31:0] memWdata,
    input  wire logic [31:0] memRdata,
    input  wire logic        memAck,
    output logic      [3:0]  chanIrq,
    output logic             engineIdle
);
    dsq_pkg::dsq_regs_t s;
    dsq_pkg::dsq_regs_t next_s;
    logic [3:0]  dbHit;
    logic [31:0] cmd0;
    logic [31:0] cmd1;
    logic        finish;
    logic [2:0]  found;

    // advance one side by a word, honouring block, stride and mode
    function automatic dsq_pkg::dsq_side_t stepSide(
        input dsq_pkg::dsq_side_t sd,
        input logic [31:0]        p,
        input logic               twoDim
    );
        dsq_pkg::dsq_side_t r;
        logic [11:0] blk;
        logic [11:0] str;
        logic [5:0]  sc;
        r   = sd;
        blk = p[dsq_pkg::P_BLK -: 12];
        str = p[dsq_pkg::P_STR -: 12];
        sc  = p[dsq_pkg::P_SC -: 6];
        if (p[dsq_pkg::P_AM -: 2] == dsq_pkg::AM_INCR)
        begin
            r.addr = sd.addr + dsq_pkg::WORD_BYTES;
            r.bcnt = sd.bcnt + 12'h4;
            if (blk != 12'h0 && str != 12'h0 && r.bcnt >= blk)
            begin
                r.bcnt = 12'h0;
                r.iter = sd.iter + 6'h1;
                if (twoDim && sc != 6'h0 && r.iter == sc)
                begin
                    r.iter = 6'h0;
                    r.grp  = sd.grp + {20'h0, blk};
                    r.base = r.grp;
                end
                else
                begin
                    r.base = sd.base + {20'h0, str};
                end
                r.addr = r.base;
            end
        end
        return r;
    endfunction

    // start state of a side at its pointer
    function automatic dsq_pkg::dsq_side_t initSide(input logic [31:0] a);
        dsq_pkg::dsq_side_t r;
        r      = '0;
        r.addr = a;
        r.base = a;
        r.grp  = a;
        return r;
    endfunction

    // rotating search for an enabled channel with a pending doorbell
    function automatic logic [2:0] pick(
        input logic [3:0] ready,
        input logic [1:0] start
    );
        logic [2:0] r;
        logic [1:0] idx;
        r = 3'h0;
        for (int k = dsq_pkg::NCH - 1; k >= 0; k--)
        begin
            idx = start + 2'(k);
            if (ready[idx])
            begin
                r = {1'b1, idx};
            end
        end
        return r;
    endfunction

    assign cmd0 = s.desc[0];
    assign cmd1 = s.desc[dsq_pkg::W_CMD1];

    // doorbell writes decoded per channel
    always_comb
    begin
        dbHit = 4'h0;
        if (regWr && regAddr[7:6] == dsq_pkg::R_CH_SPACE
            && regAddr[3:0] == dsq_pkg::R_CH_DBELL)
        begin
            dbHit[regAddr[5:4]] = 1'b1;
        end
    end

    assign found = pick(s.en & s.pend, s.rr);

    // next-state logic: register port, then sequencer
    always_comb
    begin
        next_s = s;
        finish = 1'b0;
        // register writes; doorbell set wins over sequencer clear
        if (regWr)
        begin
            if (regAddr == dsq_pkg::R_GCFG)
            begin
                next_s.highPoolArbPolicy = regWdata[0];
                next_s.lowPoolArbPolicy  = regWdata[1];
            end
            if (regAddr == dsq_pkg::R_INTEN)
                next_s.inten = regWdata[3:0];
            if (regAddr == dsq_pkg::R_THROTTLE)
                next_s.throttle = regWdata[15:0];
            if (regAddr == dsq_pkg::R_STATUS)
                next_s.irq = s.irq & ~regWdata[3:0];
            if (regAddr[7:6] == dsq_pkg::R_CH_SPACE)
            begin
                if (regAddr[3:0] == dsq_pkg::R_CH_CFG)
                    next_s.en[regAddr[5:4]] = regWdata[0];
                if (regAddr[3:0] == dsq_pkg::R_CH_PTR)
                    next_s.desptr[regAddr[5:4]] = {regWdata[31:5], 5'h0};
            end
        end
        next_s.pend = s.pend | dbHit;
        // read data stands in the cycle after the strobe only
        next_s.rdata = 32'h0;
        if (regRd)
        begin
            case (regAddr)
                dsq_pkg::R_GCFG:
                    next_s.rdata = {30'h0, s.lowPoolArbPolicy,
                                    s.highPoolArbPolicy};
                dsq_pkg::R_INTEN:    next_s.rdata = {28'h0, s.inten};
                dsq_pkg::R_THROTTLE: next_s.rdata = {16'h0, s.throttle};
                dsq_pkg::R_STATUS:
                    next_s.rdata = {23'h0, engineIdle, s.pend, s.irq};
                default:
                begin
                    if (regAddr[7:6] == dsq_pkg::R_CH_SPACE)
                    begin
                        if (regAddr[3:0] == dsq_pkg::R_CH_CFG)
                            next_s.rdata = {31'h0, s.en[regAddr[5:4]]};
                        if (regAddr[3:0] == dsq_pkg::R_CH_PTR)
                            next_s.rdata = s.desptr[regAddr[5:4]];
                    end
                end
            endcase
        end
        // descriptor sequencer
        case (s.state)
            dsq_pkg::ST_IDLE:
            begin
                if (found[2])
                begin
                    next_s.ch      = found[1:0];
                    next_s.w       = 3'h0;
                    next_s.memReq  = 1'b1;
                    next_s.memWe   = 1'b0;
                    next_s.memAddr = {4'h0, s.desptr[found[1:0]]};
                    next_s.state   = dsq_pkg::ST_FETCH;
                end
            end
            dsq_pkg::ST_FETCH:
            begin
                if (memAck)
                begin
                    next_s.desc[s.w] = memRdata;
                    next_s.w         = s.w + 3'h1;
                    next_s.memAddr   = s.memAddr + 36'h4;
                    if (s.w == dsq_pkg::W_LAST)
                    begin
                        next_s.memReq = 1'b0;
                        next_s.take   = 1'b0;
                        next_s.remain = cmd1[dsq_pkg::C1_BC -: 22];
                        next_s.src = initSide(s.desc[dsq_pkg::W_SRC0]);
                        next_s.dst = initSide(s.desc[dsq_pkg::W_DST0]);
                        if (!cmd0[dsq_pkg::C0_VALID])
                        begin
                            // stall; same descriptor refetched later
                            next_s.pend[s.ch] = dbHit[s.ch];
                            next_s.state      = dsq_pkg::ST_IDLE;
                        end
                        else if (cmd0[dsq_pkg::C0_DT -: 2]
                                 == dsq_pkg::DT_BRANCH)
                        begin
                            next_s.memReq  = 1'b1;
                            next_s.memAddr = {cmd1[dsq_pkg::C1_SUP -: 4],
                                              s.desc[dsq_pkg::W_SRC0]};
                            next_s.state   = dsq_pkg::ST_CMP;
                        end
                        else if (cmd1[dsq_pkg::C1_BC -: 22] == 22'h0)
                        begin
                            finish = 1'b1;
                        end
                        else
                        begin
                            next_s.memReq  = 1'b1;
                            next_s.memAddr = {cmd1[dsq_pkg::C1_SUP -: 4],
                                              s.desc[dsq_pkg::W_SRC0]};
                            next_s.state   = dsq_pkg::ST_SRC;
                        end
                    end
                end
            end
            dsq_pkg::ST_SRC:
            begin
                if (memAck)
                begin
                    next_s.memWe    = 1'b1;
                    next_s.memWdata = memRdata;
                    next_s.memAddr  = {cmd1[dsq_pkg::C1_DUP -: 4],
                                       s.dst.addr};
                    next_s.state    = dsq_pkg::ST_DST;
                end
            end
            dsq_pkg::ST_DST:
            begin
                if (memAck)
                begin
                    next_s.src = stepSide(s.src, s.desc[dsq_pkg::W_SRC1],
                                          cmd0[dsq_pkg::C0_SM]);
                    next_s.dst = stepSide(s.dst, s.desc[dsq_pkg::W_DST1],
                                          cmd0[dsq_pkg::C0_SM]);
                    next_s.memWe = 1'b0;
                    if (s.remain <= dsq_pkg::WORD_BC)
                    begin
                        next_s.remain = 22'h0;
                        finish        = 1'b1;
                    end
                    else
                    begin
                        next_s.remain  = s.remain - dsq_pkg::WORD_BC;
                        next_s.memAddr = {cmd1[dsq_pkg::C1_SUP -: 4],
                                          next_s.src.addr};
                        next_s.state   = dsq_pkg::ST_SRC;
                    end
                end
            end
            dsq_pkg::ST_CMP:
            begin
                if (memAck)
                begin
                    next_s.take = (memRdata & s.desc[dsq_pkg::W_DST1])
                                  == s.desc[dsq_pkg::W_DST0];
                    finish = 1'b1;
                end
            end
            dsq_pkg::ST_WB:
            begin
                if (memAck)
                begin
                    next_s.memReq = 1'b0;
                    next_s.memWe  = 1'b0;
                    next_s.state  = dsq_pkg::ST_DONE;
                end
            end
            dsq_pkg::ST_DONE:
            begin
                if (cmd0[dsq_pkg::C0_IE])
                    next_s.irq[s.ch] = 1'b1;
                next_s.desptr[s.ch] = s.take
                    ? {s.desc[dsq_pkg::W_CMD1][26:0], 5'h0}
                    : {s.desc[dsq_pkg::W_NEXT][26:0], 5'h0};
                next_s.rr    = s.ch + 2'h1;
                next_s.state = dsq_pkg::ST_IDLE;
            end
            default:
                next_s.state = dsq_pkg::ST_IDLE;
        endcase
        // completion: optional write-back of command word with valid clear
        if (finish)
        begin
            if (cmd0[dsq_pkg::C0_CV])
            begin
                next_s.memReq   = 1'b1;
                next_s.memWe    = 1'b1;
                next_s.memAddr  = {4'h0, s.desptr[s.ch]};
                next_s.memWdata = cmd0 & ~(32'h1 << dsq_pkg::C0_VALID);
                next_s.state    = dsq_pkg::ST_WB;
            end
            else
            begin
                next_s.memReq = 1'b0;
                next_s.memWe  = 1'b0;
                next_s.state  = dsq_pkg::ST_DONE;
            end
        end
    end

    // state register
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            s <= dsq_pkg::REGS_RST;
        else
            s <= next_s;
    end

    assign regRdata   = s.rdata;
    assign memReq     = s.memReq;
    assign memWe      = s.memWe;
    assign memAddr    = s.memAddr;
    assign memWdata   = s.memWdata;
    assign chanIrq    = s.irq & s.inten;
    assign engineIdle = (s.en == 4'h0) && (s.state == dsq_pkg::ST_IDLE);

    // helpers for the checks below
    logic [1:0]  curCh;
    logic [31:0] dstAddr;
    logic [21:0] remainCur;
    logic [31:0] nextPtr;
    assign curCh     = s.ch;
    assign dstAddr   = s.dst.addr;
    assign remainCur = s.remain;
    assign nextPtr   = {s.desc[dsq_pkg::W_NEXT][26:0], 5'h0};

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_lastFetch;
        s.state == dsq_pkg::ST_FETCH && memAck && s.w == dsq_pkg::W_LAST;
    endsequence
    sequence s_wordWritten;
        s.state == dsq_pkg::ST_DST && memAck && s.remain > dsq_pkg::WORD_BC;
    endsequence

    property p_dbell;
        regWr && regAddr == 8'h44 |=> s.pend[0];
    endproperty
    a_dbell: assert property (p_dbell)
        else $error("doorbell did not mark channel pending");

    property p_idleWait;
        s.state == dsq_pkg::ST_IDLE && (s.en & s.pend) == 4'h0
            |=> s.state == dsq_pkg::ST_IDLE && !memReq;
    endproperty
    a_idleWait: assert property (p_idleWait)
        else $error("idle channel started without doorbell");

    property p_validRuns;
        s_lastFetch ##0 cmd0[dsq_pkg::C0_VALID]
            |=> s.state != dsq_pkg::ST_IDLE;
    endproperty
    a_validRuns: assert property (p_validRuns)
        else $error("valid descriptor not executed");

    property p_invalidStall;
        s_lastFetch ##0 (!cmd0[dsq_pkg::C0_VALID] && dbHit == 4'h0)
            |=> s.state == dsq_pkg::ST_IDLE && !s.pend[$past(curCh)];
    endproperty
    a_invalidStall: assert property (p_invalidStall)
        else $error("invalid descriptor did not stall channel");

    property p_nextPtr;
        s.state == dsq_pkg::ST_DONE && !s.take && !regWr
            |=> s.desptr[$past(curCh)] == $past(nextPtr);
    endproperty
    a_nextPtr: assert property (p_nextPtr)
        else $error("descriptor pointer not advanced");

    property p_countDown;
        s_wordWritten |=> remainCur == $past(remainCur) - 22'h4;
    endproperty
    a_countDown: assert property (p_countDown)
        else $error("byte count not reduced by one word");

    property p_incr;
        s_wordWritten ##0 (s.desc[dsq_pkg::W_DST1][31:30] == 2'h0
            && (s.desc[dsq_pkg::W_DST1][11:0] == 12'h0
            || s.dst.bcnt + 12'h4 < s.desc[dsq_pkg::W_DST1][11:0]))
            |=> dstAddr == $past(dstAddr) + 32'h4;
    endproperty
    a_incr: assert property (p_incr)
        else $error("destination address did not increment");

    property p_irqSet;
        s.state == dsq_pkg::ST_DONE && cmd0[dsq_pkg::C0_IE]
            |=> s.irq[$past(curCh)];
    endproperty
    a_irqSet: assert property (p_irqSet)
        else $error("completion flag not raised");

    property p_shutdown;
        engineIdle && !regWr |=> engineIdle ##1 !memReq;
    endproperty
    a_shutdown: assert property (p_shutdown)
        else $error("engine active after all channels disabled");
endmodule
`default_nettype wire

// ### test/dsq_mem_model.sv
// system memory model answering the sequencer's memory master
`timescale 1ns/1ps
`default_nettype none
module dsq_mem_model (
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        memReq,
    input  wire logic        memWe,
    input  wire logic [35:0] memAddr,
    input  wire logic [31:0] memWdata,
    output logic      [31:0] memRdata,
    output logic             memAck
);
    logic [31:0] mem [0:1023];
    int          waitN;
    // one ack per request after a random wait, data toggles when idle
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            memAck <= 1'b0;
            memRdata <= 32'h0;
            waitN <= 0;
        end
        else
        begin
            memAck <= 1'b0;
            memRdata <= ~memRdata;
            if (memReq && !memAck && waitN != 0)
                waitN <= waitN - 1;
            else if (memReq && !memAck)
            begin
                memAck <= 1'b1;
                waitN <= $urandom % 3;
                if (memWe)
                    mem[memAddr[11:2]] <= memWdata;
                else
                    memRdata <= mem[memAddr[11:2]];
            end
        end
    end
endmodule
`default_nettype wire

// ### test/dsq_sequencer_tb.sv
// self-checking bench of the descriptor dma sequencer
`timescale 1ns/1ps
`default_nettype none
module dsq_sequencer_tb;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWdata = 32'h0;
    logic        regWr = 1'b0;
    logic        regRd = 1'b0;
    logic [31:0] regRdata;
    logic        memReq;
    logic        memWe;
    logic        memAck;
    logic [35:0] memAddr;
    logic [31:0] memWdata;
    logic [31:0] memRdata;
    logic [3:0]  chanIrq;
    logic        engineIdle;
    int          mismatches = 0;
    int          n_checks = 0;
    int          nReq = 0;
    int          nStall = 0;
    int          t;
    logic [67:0] wq[$];
    logic [67:0] eq[$];
    logic [31:0] rd;
    // descriptor A: 1d scatter with irq; B: 2d without irq
    logic [31:0] dest_stride_iterations [16] = '{32'hc0000104, 32'h12000010, 32'h400, 32'h0,
        32'h800, 32'h00010008, 32'h0, 32'h9, 32'hc0004004, 32'h12000020,
        32'h440, 32'h0, 32'h900, 32'h02020008, 32'h0, 32'ha};
    // branch descriptor: masked compare of word at 0x100, target 0x160
    logic [31:0] br [8] = '{32'h80020000, 32'hb, 32'h100, 32'h0,
        32'h40000104, 32'hffffffff, 32'h0, 32'h9};

    always #2.5 clk = ~clk;

    dsq_sequencer i_dut (.clk(clk), .arst_n(arst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .memReq(memReq), .memWe(memWe),
        .memAddr(memAddr), .memWdata(memWdata), .memRdata(memRdata),
        .memAck(memAck), .chanIrq(chanIrq), .engineIdle(engineIdle));

    dsq_mem_model i_mem (.clk(clk), .arst_n(arst_n), .memReq(memReq),
        .memWe(memWe), .memAddr(memAddr), .memWdata(memWdata),
        .memRdata(memRdata), .memAck(memAck));

    // memory traffic monitor
    always @(posedge clk)
    begin
        if (memReq)
            nReq++;
        if (memAck && memWe)
            wq.push_back({memAddr, memWdata});
        if (memAck && !memWe && memAddr == 36'h140)
            nStall++;
    end

    task automatic chk(input string nm, input logic [67:0] e,
                       input logic [67:0] g);
        n_checks++;
        if (g !== e)
        begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            mismatches++;
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // watchdog
    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        test_done();
    end

    initial
    begin
        void'($urandom(28));
        // descriptors complete in memory before start
        for (int i = 0; i < 1024; i++)
            i_mem.mem[i] = $urandom;
        for (int i = 0; i < 16; i++)
            i_mem.mem[16'h40 + i] = dest_stride_iterations[i];
        for (int i = 0; i < 16; i++)
            i_mem.mem[16'h50 + i] = 32'h0;
        // expected writes: 1d scatter, write-back, 2d groups, write-back
        for (int i = 0; i < 4; i++)
            eq.push_back({4'h2, 32'h800 + (i / 2) * 16 + (i % 2) * 4,
                          i_mem.mem[16'h100 + i]});
        eq.push_back({36'h100, 32'h40000104});
        for (int i = 0; i < 8; i++)
            eq.push_back({4'h2, 32'h900 + (i / 4) * 8 + ((i % 4) / 2) * 32
                          + (i % 2) * 4, i_mem.mem[16'h110 + i]});
        eq.push_back({36'h120, 32'h40004004});
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        reg_rd(dsq_pkg::R_STATUS, rd);
        chk("status", 32'h100, rd);
        reg_rd(8'h20, rd);
        chk("unmapped", 32'h0, rd);
        reg_wr(dsq_pkg::R_GCFG, 32'h3);
        reg_rd(dsq_pkg::R_GCFG, rd);
        chk("gcfg", 32'h3, rd[1:0]);
        reg_wr(dsq_pkg::R_INTEN, 32'h1);
        reg_wr(dsq_pkg::R_THROTTLE, 32'h1234);
        reg_rd(dsq_pkg::R_THROTTLE, rd);
        chk("throttle", 32'h1234, rd);
        reg_wr(8'h48, 32'h100);
        reg_rd(8'h48, rd);
        chk("pointer", 32'h100, rd);
        reg_wr(8'h40, 32'h1);
        repeat (20) @(posedge clk);
        chk("idle requests", 0, nReq);
        reg_wr(8'h44, 32'h0);
        for (t = 0; t < 6000 && (wq.size() < 14 || nStall < 1); t++)
            @(posedge clk);
        repeat (30) @(posedge clk);
        #1;
        chk("writes", 14, wq.size());
        for (int i = 0; i < 14 && i < wq.size(); i++)
            chk("mem write", eq[i], wq[i]);
        chk("stall fetch", 1, nStall);
        chk("irq", 4'h1, chanIrq);
        reg_rd(8'h48, rd);
        chk("next pointer", 32'h140, rd);
        reg_rd(dsq_pkg::R_STATUS, rd);
        chk("flags", 4'h1, rd[3:0]);
        reg_wr(dsq_pkg::R_STATUS, 32'h1);
        reg_rd(dsq_pkg::R_STATUS, rd);
        chk("flags clear", 4'h0, rd[3:0]);
        reg_wr(8'h44, 32'h0);
        for (t = 0; t < 2000 && nStall < 2; t++)
            @(posedge clk);
        repeat (20) @(posedge clk);
        #1;
        chk("refetch", 2, nStall);
        chk("irq after stall", 4'h0, chanIrq);
        // stalled slot rewritten as a branch whose compare matches
        for (int i = 0; i < 8; i++)
            i_mem.mem[16'h50 + i] = br[i];
        reg_wr(8'h44, 32'h0);
        for (t = 0; t < 2000 && nStall < 3; t++)
            @(posedge clk);
        repeat (100) @(posedge clk);
        reg_rd(8'h48, rd);
        chk("branch pointer", 32'h160, rd);
        reg_wr(8'h40, 32'h0);
        for (t = 0; t < 1000 && engineIdle !== 1'b1; t++)
            @(posedge clk);
        #1;
        chk("engine idle", 1'b1, engineIdle);
        chk("no extra writes", 14, wq.size());
        test_done();
    end
endmodule
`default_nettype wire
